// ===== rtl/rcp_regs.svh
`ifndef RCP_REGS_SVH
`define RCP_REGS_SVH
// Bus geometry and answers
`define RCP_ADDR_W 8
`define RCP_RESP_OKAY 2'b00
`define RCP_RESP_SLVERR 2'b10
// Register byte offsets
`define RCP_CTRL_OFF 8'h00
`define RCP_COLSEL_OFF 8'h04
`define RCP_PWRVAL_OFF 8'h08
`define RCP_PREEN_OFF 8'h0c
`define RCP_CLKSEL_OFF 8'h10
`define RCP_CLRSEL_OFF 8'h14
`define RCP_OESRC_OFF 8'h18
`define RCP_OEGSEL_OFF 8'h1c
`define RCP_OEROUTE_OFF 8'h20
`define RCP_STATUS_OFF 8'h24
`define RCP_QVAL_OFF 8'h28
// Control fields
`define RCP_CTRL_RST_EN 0
`define RCP_CTRL_OE_EN 1
`define RCP_CTRL_PWRUP 2
// Column select fields
`define RCP_COL_EN_LSB 0
`define RCP_COL_CLK0_LSB 4
`define RCP_COL_CLK1_LSB 6
`define RCP_COL_CLR_LSB 8
`define RCP_COLSEL_W 10
`define RCP_COLSEL_RST 10'h24f
// Status fields
`define RCP_ST_HELD 0
`define RCP_ST_RSTPIN 1
`define RCP_ST_OEPIN 2
`endif

// ===== rtl/rcp_pkg.sv
package rcp_pkg;
  // Per-register clear source, two bits each
  typedef enum logic [1:0] {
    RCP_CLR_NONE,
    RCP_CLR_A,
    RCP_CLR_B,
    RCP_CLR_BOTH
  } rcp_clr_sel_t;
  typedef logic [1:0] rcp_line_sel_t;
endpackage

// ===== rtl/rcp_block.sv
// What this block does
// - Each register has data, async data, clock, enable, clear, async load.
// - Preset is an asynchronous load of logic one.
// - Clear wins over preset or async load when both are asserted.
// - Block offers two shared clears and one shared preset.
// - Enabled active-low chip reset clears all registers, overriding all.
// - Chip reset uses its own path, none of four global lines.
// - Reset pin low at power-up keeps clears held until released.
// - With reset function off the pin is plain I/O, no effect.
// - Registers power up low; per-register option powers them up high.
// - Four column lines select two block clocks and one block clear.
// - Unused column lines are switched off at the column buffers.
// - Each pin enable comes from a global line or general routing.
// - Output enable function on: pin high drives, pin low tri-states all.
// - Output enable function off: pin ignored, readable as user I/O.
`include "rcp_regs.svh"
module rcp_block
  import rcp_pkg::*;
#(
  parameter int REGS = 10,
  parameter bit RST_FUNC_DEFAULT = 1'b1,
  parameter bit OE_FUNC_DEFAULT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`RCP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`RCP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] global_signal_line,
  input wire logic chip_wide_reset_n,
  input wire logic chip_wide_output_enable,
  input wire logic blk_clear_a,
  input wire logic blk_clear_b,
  input wire logic blk_preset,
  input wire logic [REGS-1:0] reg_d,
  input wire logic [REGS-1:0] reg_adata,
  input wire logic [REGS-1:0] reg_ce,
  input wire logic [REGS-1:0] reg_aload,
  output logic [REGS-1:0] reg_q,
  output logic [REGS-1:0] pin_oe_n
);

  // Bus side state
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [`RCP_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next, wv;
  logic do_wr;
  // Configuration state
  logic rst_func_reg, rst_func_next, oe_func_reg, oe_func_next;
  logic pwrup_cmd_reg, pwrup_cmd_next;
  logic [`RCP_COLSEL_W-1:0] colsel_reg, colsel_next;
  logic [REGS-1:0] pwr_val_reg, pwr_val_next, pre_en_reg, pre_en_next;
  logic [REGS-1:0] clk_sel_reg, clk_sel_next, oe_src_reg, oe_src_next;
  logic [REGS-1:0] oe_route_reg, oe_route_next;
  logic [2*REGS-1:0] clr_sel_reg, clr_sel_next, oe_gsel_reg, oe_gsel_next;
  // Core state
  logic [REGS-1:0] q_reg, q_next, oe_n_reg, oe_n_next;
  logic [3:0] col_prev_reg, col_prev_next, col_line;
  logic held_reg, held_next, pend_reg, pend_next;
  logic edge0, edge1, col_clear, clr_a, rst_act, pwr_load;
  logic [REGS-1:0] clr_v, al_v;
  // Checks below all run on the bus clock, quiet during reset
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // One line out of four, used for clocks, clear and pin enables
  function automatic logic pick4(input logic [3:0] v,
                                 input rcp_line_sel_t s);
    pick4 = v[s];
  endfunction

  // Decoded offsets; everything else answers with an error
  function automatic logic addr_ok(input logic [`RCP_ADDR_W-1:0] a);
    addr_ok = (a <= `RCP_QVAL_OFF) && (a[1:0] == 2'b00);
  endfunction

  // Byte lanes merge new data over the current word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b+:8] = strb[b] ? nw[8*b+:8] : old[8*b+:8];
    end
  endfunction

  // Register readback, shared by reads and byte-lane writes
  function automatic logic [31:0] read_word(
      input logic [`RCP_ADDR_W-1:0] a);
    case (a)
      `RCP_CTRL_OFF: read_word = 32'({oe_func_reg, rst_func_reg});
      `RCP_COLSEL_OFF: read_word = 32'(colsel_reg);
      `RCP_PWRVAL_OFF: read_word = 32'(pwr_val_reg);
      `RCP_PREEN_OFF: read_word = 32'(pre_en_reg);
      `RCP_CLKSEL_OFF: read_word = 32'(clk_sel_reg);
      `RCP_CLRSEL_OFF: read_word = 32'(clr_sel_reg);
      `RCP_OESRC_OFF: read_word = 32'(oe_src_reg);
      `RCP_OEGSEL_OFF: read_word = 32'(oe_gsel_reg);
      `RCP_OEROUTE_OFF: read_word = 32'(oe_route_reg);
      // Pin levels stay visible so an unused pin serves as plain input
      `RCP_STATUS_OFF: read_word = 32'({chip_wide_output_enable,
                                         chip_wide_reset_n, held_reg});
      `RCP_QVAL_OFF: read_word = 32'(q_reg);
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // Bus handshakes; address and data may arrive in either order
  always_comb begin
    do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
    aw_got_next = (aw_got_reg || (s_axi_awvalid && awready_reg)) && !do_wr;
    w_got_next = (w_got_reg || (s_axi_wvalid && wready_reg)) && !do_wr;
    aw_addr_next = (s_axi_awvalid && awready_reg) ? s_axi_awaddr
                                                  : aw_addr_reg;
    w_data_next = (s_axi_wvalid && wready_reg) ? s_axi_wdata : w_data_reg;
    w_strb_next = (s_axi_wvalid && wready_reg) ? s_axi_wstrb : w_strb_reg;
    bvalid_next = do_wr || (bvalid_reg && !s_axi_bready);
    bresp_next = bresp_reg;
    if (do_wr) begin
      bresp_next = addr_ok(aw_addr_reg) ? `RCP_RESP_OKAY : `RCP_RESP_SLVERR;
    end
    // No new write is taken until the last answer is consumed
    awready_next = !aw_got_next && !bvalid_next;
    wready_next = !w_got_next && !bvalid_next;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next = read_word(s_axi_araddr);
      rresp_next = addr_ok(s_axi_araddr) ? `RCP_RESP_OKAY
                                         : `RCP_RESP_SLVERR;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RCP_RESP_OKAY;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RCP_RESP_OKAY;
      arready_reg <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      arready_reg <= arready_next;
    end
  end

  // Configuration writes; power-up command is a one-cycle pulse
  always_comb begin
    wv = merge(read_word(aw_addr_reg), w_data_reg, w_strb_reg);
    rst_func_next = rst_func_reg;
    oe_func_next = oe_func_reg;
    pwrup_cmd_next = 1'b0;
    colsel_next = colsel_reg;
    pwr_val_next = pwr_val_reg;
    pre_en_next = pre_en_reg;
    clk_sel_next = clk_sel_reg;
    clr_sel_next = clr_sel_reg;
    oe_src_next = oe_src_reg;
    oe_gsel_next = oe_gsel_reg;
    oe_route_next = oe_route_reg;
    if (do_wr) begin
      case (aw_addr_reg)
        `RCP_CTRL_OFF: begin
          rst_func_next = wv[`RCP_CTRL_RST_EN];
          oe_func_next = wv[`RCP_CTRL_OE_EN];
          pwrup_cmd_next = w_strb_reg[0] && w_data_reg[`RCP_CTRL_PWRUP];
        end
        `RCP_COLSEL_OFF: colsel_next = wv[`RCP_COLSEL_W-1:0];
        `RCP_PWRVAL_OFF: pwr_val_next = wv[REGS-1:0];
        `RCP_PREEN_OFF: pre_en_next = wv[REGS-1:0];
        `RCP_CLKSEL_OFF: clk_sel_next = wv[REGS-1:0];
        `RCP_CLRSEL_OFF: clr_sel_next = wv[2*REGS-1:0];
        `RCP_OESRC_OFF: oe_src_next = wv[REGS-1:0];
        `RCP_OEGSEL_OFF: oe_gsel_next = wv[2*REGS-1:0];
        `RCP_OEROUTE_OFF: oe_route_next = wv[REGS-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_func_reg <= RST_FUNC_DEFAULT;
      oe_func_reg <= OE_FUNC_DEFAULT;
      pwrup_cmd_reg <= 1'b0;
      colsel_reg <= `RCP_COLSEL_RST;
      pwr_val_reg <= '0;
      pre_en_reg <= '0;
      clk_sel_reg <= '0;
      clr_sel_reg <= '0;
      oe_src_reg <= '0;
      oe_gsel_reg <= '0;
      oe_route_reg <= '0;
    end else begin
      rst_func_reg <= rst_func_next;
      oe_func_reg <= oe_func_next;
      pwrup_cmd_reg <= pwrup_cmd_next;
      colsel_reg <= colsel_next;
      pwr_val_reg <= pwr_val_next;
      pre_en_reg <= pre_en_next;
      clk_sel_reg <= clk_sel_next;
      clr_sel_reg <= clr_sel_next;
      oe_src_reg <= oe_src_next;
      oe_gsel_reg <= oe_gsel_next;
      oe_route_reg <= oe_route_next;
    end
  end

  // Register cells; clock edges of the column lines become enables
  always_comb begin
    col_line = global_signal_line & colsel_reg[`RCP_COL_EN_LSB+:4];
    col_prev_next = col_line;
    // two block clocks and one block clear from four lines
    edge0 = pick4(col_line, colsel_reg[`RCP_COL_CLK0_LSB+:2]) &&
            !pick4(col_prev_reg, colsel_reg[`RCP_COL_CLK0_LSB+:2]);
    edge1 = pick4(col_line, colsel_reg[`RCP_COL_CLK1_LSB+:2]) &&
            !pick4(col_prev_reg, colsel_reg[`RCP_COL_CLK1_LSB+:2]);
    col_clear = pick4(col_line, colsel_reg[`RCP_COL_CLR_LSB+:2]);
    // two shared clears, column clear folded into the first
    clr_a = blk_clear_a || col_clear;
    // chip reset enters here directly, never via the global lines
    // pin has no reset effect when the function is off
    rst_act = rst_func_reg && (!chip_wide_reset_n || held_reg);
    // clears stay held from power-up until the pin is released
    held_next = held_reg && rst_func_reg && !chip_wide_reset_n;
    // A held clear cancels the pending power-up preload
    pend_next = 1'b0;
    pwr_load = (pend_reg || pwrup_cmd_reg) && !rst_act;
    q_next = q_reg;
    // per-cell data, async data, enable, clear and load inputs
    for (int i = 0; i < REGS; i++) begin
      clr_v[i] = (clr_sel_reg[2*i] && clr_a) ||
                 (clr_sel_reg[2*i+1] && blk_clear_b);
      // preset is an async load forcing a one
      al_v[i] = reg_aload[i] || (pre_en_reg[i] && blk_preset);
      // chip reset overrides, then clear beats load
      if (rst_act || clr_v[i]) begin
        q_next[i] = 1'b0;
      end else if (pwr_load) begin
        q_next[i] = pwr_val_reg[i];
      end else if (al_v[i]) begin
        q_next[i] = reg_aload[i] ? reg_adata[i] : 1'b1;
      // clocked capture only with clock enable
      end else if ((clk_sel_reg[i] ? edge1 : edge0) && reg_ce[i]) begin
        q_next[i] = reg_d[i];
      end
    end
  end

  // Pin enables, registered so a pin never glitches
  always_comb begin
    for (int i = 0; i < REGS; i++) begin
      // per-pin source, global line or routing bit
      // function on and pin low tri-states every output
      // function off leaves the pin out of the enable path
      oe_n_next[i] = !((oe_src_reg[i]
          ? pick4(global_signal_line, oe_gsel_reg[2*i+:2])
          : oe_route_reg[i]) && (!oe_func_reg || chip_wide_output_enable));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0;
      oe_n_reg <= '1;
      col_prev_reg <= 4'h0;
      held_reg <= 1'b1;
      pend_reg <= 1'b1;
    end else begin
      q_reg <= q_next;
      oe_n_reg <= oe_n_next;
      col_prev_reg <= col_prev_next;
      held_reg <= held_next;
      pend_reg <= pend_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign reg_q = q_reg;
  assign pin_oe_n = oe_n_reg;

  a_clear_over_load: assert property (
    (clr_v[0] && al_v[0]) |=> !reg_q[0])
    else $error("clear did not win over load");
  a_preset_gives_one: assert property (
    (blk_preset && pre_en_reg[0] && !reg_aload[0] && !clr_v[0] &&
     !rst_act && !pwr_load) |=> reg_q[0])
    else $error("preset did not load one");
  a_chip_reset_all: assert property (
    (rst_func_reg && !chip_wide_reset_n) |=> (reg_q == '0))
    else $error("chip reset left a register set");
  a_reset_pin_off: assert property (
    !rst_func_reg |-> !rst_act)
    else $error("disabled reset pin acted");
  a_held_until_free: assert property (
    (held_reg && !chip_wide_reset_n && rst_func_reg) |=> held_reg)
    else $error("power-up clear released early");
  a_powerup_value: assert property (
    (pwrup_cmd_reg && !rst_act && clr_v == '0) |=>
      (reg_q == $past(pwr_val_reg)))
    else $error("power-up value not loaded");
  a_col_line_off: assert property (
    !colsel_reg[colsel_reg[`RCP_COL_CLK0_LSB+:2]] |-> !edge0)
    else $error("switched-off line clocked a register");
  a_hold_no_enable: assert property (
    (!reg_ce[0] && !al_v[0] && !clr_v[0] && !rst_act && !pwr_load)
      |=> $stable(reg_q[0]))
    else $error("register changed without enable");
  a_oe_chip_off: assert property (
    (oe_func_reg && !chip_wide_output_enable) |=> (pin_oe_n == '1))
    else $error("output driven while chip enable low");
  a_oe_route_pin: assert property (
    (!oe_func_reg && !oe_src_reg[0]) |=>
      (pin_oe_n[0] == !$past(oe_route_reg[0])))
    else $error("pin enable ignored routing bit");

endmodule

// ===== tb/rcp_board.sv
// Board-side driver of the chip-wide reset and output enable pins
module rcp_board (
  input wire logic aclk,
  input wire logic hold_reset,
  input wire logic drive_enable,
  input wire logic slow,
  output logic chip_wide_reset_n,
  output logic chip_wide_output_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rst_pipe;
  logic [2:0] oe_pipe;
  // Slow board: pins follow three cycles late, as a sluggish supervisor would
  always @(posedge aclk) begin
    rst_pipe <= {rst_pipe[1:0], hold_reset};
    oe_pipe <= {oe_pipe[1:0], drive_enable};
  end
  assign chip_wide_reset_n = !(slow ? rst_pipe[2] : hold_reset);
  // enable high while outputs may drive
  assign chip_wide_output_enable = slow ? oe_pipe[2] : drive_enable;
endmodule

// ===== tb/testbench.sv
`include "rcp_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 10;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic chip_wide_reset_n, chip_wide_output_enable;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, global_signal_line;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic hold_rst, drv_oe, slow, blk_clear_a, blk_clear_b, blk_preset;
  logic [N-1:0] reg_d, reg_adata, reg_ce, reg_aload, reg_q, pin_oe_n;
  logic [N-1:0] v, m, prev;
  logic [33:0] expq[$];
  int miscompares, total_checks, cycles, seed;

  rcp_block #(.REGS(N)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .global_signal_line, .chip_wide_reset_n, .chip_wide_output_enable,
    .blk_clear_a, .blk_clear_b, .blk_preset, .reg_d, .reg_adata,
    .reg_ce, .reg_aload, .reg_q, .pin_oe_n);
  rcp_board board (.aclk, .hold_reset(hold_rst), .drive_enable(drv_oe),
    .slow, .chip_wide_reset_n, .chip_wide_output_enable);

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Write with both halves offered together; response noted up front
  task automatic wr(input logic [7:0] a, input logic [31:0] dat,
                    input logic [1:0] er);
    logic ta, td;
    ta = 1'b0;
    td = 1'b0;
    expq.push_back({er, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && td)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        td = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    expq.push_back({er, exp});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic qv(input logic [N-1:0] e);
    // Cell outputs seen at the pins as well as over the bus
    check({24'h0, reg_q}, {24'h0, e});
    rd(`RCP_QVAL_OFF, {22'h0, e}, `RCP_RESP_OKAY);
  endtask

  // Pins are levels, so they are sampled once the board has settled
  task automatic pins(input logic [N-1:0] e);
    repeat (6) @(posedge aclk);
    check({24'h0, pin_oe_n}, {24'h0, e});
  endtask

  task automatic pulse_line0;
    @(posedge aclk);
    global_signal_line <= 4'h1;
    repeat (2) @(posedge aclk);
    global_signal_line <= 4'h0;
    @(posedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Every bus answer retires the oldest noted expectation
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      if (expq.size() == 0)
        check(34'h1, 34'h0);
      else if (s_axi_rvalid)
        check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
      else
        check({s_axi_bresp, 32'h0}, expq.pop_front());
    end
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      complete_run;
    end
  end

  initial begin
    seed = 59;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, slow, blk_clear_a} = 4'h0;
    {blk_clear_b, blk_preset} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    global_signal_line = 4'h0;
    {reg_d, reg_adata, reg_ce, reg_aload} = '0;
    hold_rst = 1'b1;
    drv_oe = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    v = N'($random(seed));
    reg_adata <= v;
    reg_aload <= '1;
    repeat (4) @(posedge aclk);
    qv('0);
    rd(`RCP_STATUS_OFF, 32'h5, `RCP_RESP_OKAY);
    hold_rst <= 1'b0;
    slow <= 1'b1;
    repeat (6) @(posedge aclk);
    qv(v);
    reg_aload <= '0;
    wr(`RCP_PREEN_OFF, 32'h3ff, `RCP_RESP_OKAY);
    blk_preset <= 1'b1;
    repeat (2) @(posedge aclk);
    qv('1);
    wr(`RCP_CLRSEL_OFF, 32'h55555, `RCP_RESP_OKAY);
    blk_clear_a <= 1'b1;
    repeat (2) @(posedge aclk);
    qv('0);
    blk_clear_a <= 1'b0;
    wr(`RCP_CLRSEL_OFF, 32'haaaaa, `RCP_RESP_OKAY);
    blk_clear_b <= 1'b1;
    repeat (2) @(posedge aclk);
    qv('0);
    blk_clear_b <= 1'b0;
    wr(`RCP_CLRSEL_OFF, 32'h55555, `RCP_RESP_OKAY);
    global_signal_line <= 4'h4;
    repeat (2) @(posedge aclk);
    qv('0);
    global_signal_line <= 4'h0;
    repeat (2) @(posedge aclk);
    qv('1);
    blk_preset <= 1'b0;
    wr(`RCP_PREEN_OFF, 32'h0, `RCP_RESP_OKAY);
    wr(`RCP_CLKSEL_OFF, 32'h0, `RCP_RESP_OKAY);
    prev = '1;
    // Random data and enables; disabled cells must keep their value
    for (int k = 0; k < 4; k++) begin
      v = N'($random(seed));
      m = N'($random(seed));
      reg_d <= v;
      reg_ce <= m;
      pulse_line0;
      prev = (v & m) | (prev & ~m);
      qv(prev);
    end
    wr(`RCP_COLSEL_OFF, 32'h24e, `RCP_RESP_OKAY);
    reg_d <= ~prev;
    reg_ce <= '1;
    pulse_line0;
    qv(prev);
    wr(`RCP_COLSEL_OFF, 32'h24f, `RCP_RESP_OKAY);
    // Second block clock: line 0 must now be ignored, line 1 captures
    wr(`RCP_CLKSEL_OFF, 32'h3ff, `RCP_RESP_OKAY);
    pulse_line0;
    qv(prev);
    global_signal_line <= 4'h2;
    repeat (2) @(posedge aclk);
    global_signal_line <= 4'h0;
    qv(~prev);
    hold_rst <= 1'b1;
    repeat (6) @(posedge aclk);
    qv('0);
    wr(`RCP_CTRL_OFF, 32'h2, `RCP_RESP_OKAY);
    reg_adata <= v;
    reg_aload <= '1;
    repeat (2) @(posedge aclk);
    qv(v);
    reg_aload <= '0;
    hold_rst <= 1'b0;
    wr(`RCP_CTRL_OFF, 32'h3, `RCP_RESP_OKAY);
    v = N'($random(seed));
    wr(`RCP_PWRVAL_OFF, {22'h0, v}, `RCP_RESP_OKAY);
    wr(`RCP_CTRL_OFF, 32'h7, `RCP_RESP_OKAY);
    qv(v);
    rd(`RCP_CTRL_OFF, 32'h3, `RCP_RESP_OKAY);
    rd(`RCP_COLSEL_OFF, 32'h24f, `RCP_RESP_OKAY);
    rd(8'h2c, 32'h0, `RCP_RESP_SLVERR);
    rd(8'h05, 32'h0, `RCP_RESP_SLVERR);
    wr(8'h30, 32'h1, `RCP_RESP_SLVERR);
    wr(`RCP_OESRC_OFF, 32'h0, `RCP_RESP_OKAY);
    wr(`RCP_OEROUTE_OFF, 32'h3ff, `RCP_RESP_OKAY);
    pins('0);
    drv_oe <= 1'b0;
    pins('1);
    wr(`RCP_CTRL_OFF, 32'h1, `RCP_RESP_OKAY);
    pins('0);
    rd(`RCP_STATUS_OFF, 32'h2, `RCP_RESP_OKAY);
    wr(`RCP_CTRL_OFF, 32'h3, `RCP_RESP_OKAY);
    drv_oe <= 1'b1;
    wr(`RCP_OESRC_OFF, 32'h3ff, `RCP_RESP_OKAY);
    wr(`RCP_OEGSEL_OFF, 32'haaaaa, `RCP_RESP_OKAY);
    global_signal_line <= 4'h4;
    pins('0);
    global_signal_line <= 4'h0;
    pins('1);
    complete_run;
  end
endmodule
